// ===== hdl/boot_select_autobaud_sync.sv
// Boot sequencer: chooses user code or serial programming, and auto-bauds only in programming.
// Assumes a UART outside it with 8N1 framing and a byte handshake.
//
// Operation
// - Entry pin low at reset: enter programming, route rx gpio0 tx gpio4
// - Sequence runs every reset, picks handler or user code
// - Entry pin sampled once, one cycle after the 3 ms wait that follows reset release
// - Watchdog flag set skips entry pin, goes to code check
// - Pin high means no request: search for valid user code
// - Valid code runs; otherwise try serial load
// - Protection word at 0x2FC can suppress pin sampling
// - Retained RAM 0x10000000-0x10000050 never written by boot
// - 8 kB boot block at 0x1FFF0000, low 512 bytes aliased at zero
// - First eight vector words must sum to zero
// - Bit time measured in 25 MHz reference cycles, scaled to 12 MHz cycles, sets baud divider
// - Device sends Synchronized CR LF, host echoes it
// - Matching echo answered with OK CR LF
// - Host frequency accepted and ignored; stay on internal oscillator
// - Handler starts; erase, write, Go refused until one Unlock
`timescale 1ns/1ps
`default_nettype none
module boot_select_autobaud_sync
    import boot_pkg::*;
#(
    parameter int DECIDE_CYCLES = DECIDE_CYC,
    parameter int DIV_W         = 16
)(
    input  wire logic               REF_CLK,
    input  wire logic               RST,
    input  wire logic               CE,
    input  wire logic               WDT_OVERFLOW,
    input  wire logic [7:0]         LOADER_VERSION,
    input  wire logic               PKG_EIGHT_PIN,
    input  wire logic               GPIO_LINE_ONE,
    input  wire logic               GPIO_LINE_TWELVE,
    input  wire logic               GPIO_LINE_ZERO,
    input  wire logic [31:0]        PROT_WORD,
    input  wire logic [31:0]        VEC_WORD,
    input  wire logic               RX_VALID,
    input  wire logic [7:0]         RX_DATA,
    input  wire logic               TX_READY,
    input  wire logic               CMD_UNLOCK,
    input  wire logic               CMD_PROTECTED,
    output logic [2:0]              VEC_INDEX,
    output logic [31:0]             ALIAS_BASE,
    output logic                    RUN_USER,
    output logic                    PROG_MODE,
    output logic                    ROUTE_SERIAL,
    output logic [DIV_W-1:0]        BAUD_DIV,
    output logic                    TX_VALID,
    output logic [7:0]              TX_DATA,
    output logic                    CMD_ACTIVE,
    output logic                    CMD_REFUSE,
    output logic                    UNLOCKED
);
    ////////////////////////////////////////////////////////////////////
    typedef struct packed {
        state_t             st;
        logic [22:0]        cnt;
        logic [31:0]        sum;
        logic [2:0]         vidx;
        logic               pin_req;
        logic [4:0]         ptr;
        logic [3:0]         left;
        logic               tx_ok;
        logic               rd_wait;
        logic               mism;
        logic               rx_prev;
        logic [DIV_W-1:0]   edge_cnt;
        logic [DIV_W-1:0]   bdiv;
        logic               meas;
        logic               timed;
        logic               run_user;
        logic               prog;
        logic               tx_valid;
        logic [7:0]         tx_data;
        logic               cmd;
        logic               refuse;
        logic               unlocked;
    } seq_t;

    seq_t r;
    seq_t next_r;
    boot_msg_if msg ();

    boot_msg_rom u_rom (
        .clk  (REF_CLK),
        .rst  (RST),
        .ce   (CE),
        .port (msg.mem)
    );

    function automatic logic pick_entry(input logic [7:0] ver,
                                        input logic eight,
                                        input logic p1,
                                        input logic p12);
        pick_entry = (ver >= VER_SPLIT && !eight) ? p12 : p1;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Fold of the bit time in reference cycles into 12 MHz ticks per bit
    localparam logic [DIV_W-1:0] DIV_ONE = {{(DIV_W-1){1'b0}}, 1'b1};

    always_comb
    begin
        next_r = r;
        next_r.tx_valid = r.tx_valid && !TX_READY;
        next_r.refuse = 1'b0;
        next_r.rx_prev = GPIO_LINE_ZERO;
        case (r.st)
            S_WAIT:
            begin
                next_r.cnt = r.cnt + 23'h000001;
                if (r.cnt >= 23'(DECIDE_CYCLES - 1))
                    next_r.st = WDT_OVERFLOW ? S_SUM : S_PIN;
            end
            S_PIN:
            begin
                next_r.pin_req = (PROT_WORD != PROT_NO_SAMPLE)
                    && !pick_entry(LOADER_VERSION, PKG_EIGHT_PIN,
                                   GPIO_LINE_ONE, GPIO_LINE_TWELVE);
                if (next_r.pin_req)
                begin
                    next_r.prog = 1'b1;
                    next_r.st = S_RXSYNC;
                end
                else
                    next_r.st = S_SUM;
            end
            S_SUM:
            begin
                next_r.sum = r.sum + VEC_WORD;
                next_r.vidx = r.vidx + 3'h1;
                if (r.vidx == 3'(VEC_WORDS - 1))
                begin
                    if (next_r.sum == 32'h00000000)
                    begin
                        next_r.run_user = 1'b1;
                        next_r.st = S_USER;
                    end
                    else
                    begin
                        next_r.prog = 1'b1;
                        next_r.st = S_RXSYNC;
                    end
                end
            end
            S_USER:
                next_r.st = S_USER;
            S_RXSYNC:
            begin
                // Start bit falling edge opens the timed bit
                if (r.rx_prev && !GPIO_LINE_ZERO && !r.meas && !r.timed)
                begin
                    next_r.meas = 1'b1;
                    next_r.edge_cnt = DIV_ONE;
                end
                else if (r.meas && !GPIO_LINE_ZERO)
                    next_r.edge_cnt = r.edge_cnt + DIV_ONE;
                else if (r.meas)
                begin
                    next_r.meas = 1'b0;
                    // One timing per attempt; later low runs ignored
                    next_r.timed = 1'b1;
                    // Low run of the sync char is the start bit alone
                    next_r.bdiv = DIV_W'((64'(r.edge_cnt) * 64'(OSC_HZ))
                                  / 64'(CLK_HZ));
                end
                if (RX_VALID && RX_DATA == SYNC_CHAR)
                begin
                    next_r.meas = 1'b0;
                    next_r.timed = 1'b0;
                    next_r.ptr = MSG_SYNC_BASE;
                    next_r.left = 4'(STR_SYNC_LEN);
                    next_r.tx_ok = 1'b0;
                    next_r.rd_wait = 1'b1;
                    next_r.st = S_TXSTR;
                end
            end
            S_TXSTR:
            begin
                if (r.rd_wait)
                    next_r.rd_wait = 1'b0;
                else if (!r.tx_valid)
                begin
                    next_r.tx_valid = 1'b1;
                    next_r.tx_data = msg.data;
                    next_r.ptr = r.ptr + 5'h01;
                    next_r.left = r.left - 4'h1;
                    next_r.rd_wait = 1'b1;
                    if (r.left == 4'h1)
                    begin
                        next_r.ptr = MSG_SYNC_BASE;
                        next_r.left = 4'(STR_SYNC_LEN);
                        next_r.mism = 1'b0;
                        next_r.st = r.tx_ok ? S_FREQ : S_ECHO;
                    end
                end
            end
            S_ECHO:
            begin
                if (r.rd_wait)
                    next_r.rd_wait = 1'b0;
                else if (RX_VALID)
                begin
                    next_r.mism = r.mism || (RX_DATA != msg.data);
                    next_r.ptr = r.ptr + 5'h01;
                    next_r.left = r.left - 4'h1;
                    next_r.rd_wait = 1'b1;
                    if (r.left == 4'h1)
                    begin
                        if (next_r.mism)
                            next_r.st = S_RXSYNC;
                        else
                        begin
                            next_r.ptr = MSG_OK_BASE;
                            next_r.left = 4'(STR_OK_LEN);
                            next_r.tx_ok = 1'b1;
                            next_r.st = S_TXSTR;
                        end
                    end
                end
            end
            S_FREQ:
                // Frequency digits end at LF; value is ignored
                if (RX_VALID && RX_DATA == CHR_LF)
                begin
                    next_r.cmd = 1'b1;
                    next_r.unlocked = 1'b0;
                    next_r.st = S_CMD;
                end
            S_CMD:
            begin
                if (CMD_UNLOCK)
                    next_r.unlocked = 1'b1;
                next_r.refuse = CMD_PROTECTED && !r.unlocked;
            end
            default:
                next_r.st = S_WAIT;
        endcase
    end

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            r <= '0;
            r.st <= S_WAIT;
            r.rx_prev <= 1'b1;
            r.bdiv <= DIV_ONE;
        end
        else if (CE)
            r <= next_r;
    end

    ////////////////////////////////////////////////////////////////////
    // Read port only: boot never writes retained memory
    assign msg.addr = r.ptr;
    assign VEC_INDEX = r.vidx;
    // Alias base is constant: boot block remains mapped at zero
    assign ALIAS_BASE = BOOT_BASE;
    assign RUN_USER = r.run_user;
    assign PROG_MODE = r.prog;
    assign ROUTE_SERIAL = r.prog;
    assign BAUD_DIV = r.bdiv;
    assign TX_VALID = r.tx_valid;
    assign TX_DATA = r.tx_data;
    assign CMD_ACTIVE = r.cmd;
    assign CMD_REFUSE = r.refuse;
    assign UNLOCKED = r.unlocked;
endmodule
`default_nettype wire

// ===== hdl/boot_pkg.sv
// Package for the boot select and auto-baud sequencer.
// Assumes a 25 MHz reference clock; serial frames are 8N1.
package boot_pkg;
    localparam int          CLK_HZ         = 25000000;
    localparam int          OSC_HZ         = 12000000;
    localparam int          DECIDE_US      = 3000;
    localparam int          DECIDE_CYC     = DECIDE_US * (CLK_HZ / 1000000);
    localparam logic [31:0] PROT_ADDR      = 32'h000002FC;
    // Value is arbitrary
    localparam logic [31:0] PROT_NO_SAMPLE = 32'h5A5AC3C3;
    localparam logic [31:0] RAM_KEEP_LO    = 32'h10000000;
    localparam logic [31:0] RAM_KEEP_HI    = 32'h10000050;
    localparam logic [31:0] BOOT_BASE      = 32'h1FFF0000;
    localparam int          BOOT_BYTES     = 8192;
    localparam int          ALIAS_BYTES    = 512;
    localparam int          VEC_WORDS      = 8;
    localparam logic [31:0] VEC_CHK_OFS    = 32'h0000001C;
    localparam logic [7:0]  SYNC_CHAR      = 8'h3F;
    localparam logic [7:0]  CHR_CR         = 8'h0D;
    localparam logic [7:0]  CHR_LF         = 8'h0A;
    localparam logic [7:0]  VER_SPLIT      = 8'h04;
    localparam int          DATA_BITS      = 8;
    localparam int          STR_SYNC_LEN   = 14;
    localparam int          STR_OK_LEN     = 4;
    localparam int          MSG_DEPTH      = 32;
    localparam logic [4:0]  MSG_SYNC_BASE  = 5'h00;
    localparam logic [4:0]  MSG_OK_BASE    = 5'h10;
    typedef enum logic [3:0] {
        S_WAIT    = 4'h0,
        S_PIN     = 4'h1,
        S_SUM     = 4'h2,
        S_USER    = 4'h3,
        S_RXSYNC  = 4'h4,
        S_TXSTR   = 4'h5,
        S_ECHO    = 4'h6,
        S_FREQ    = 4'h7,
        S_CMD     = 4'h8
    } state_t;
endpackage

// ===== hdl/boot_msg_if.sv
// Read port between the sequencer and its message memory.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface boot_msg_if;
    logic [4:0] addr;
    logic [7:0] data;
    modport seq (output addr, input data);
    modport mem (input addr, output data);
endinterface
`default_nettype wire

// ===== hdl/boot_msg_rom.sv
// Constant message memory holding the reply strings.
// Assumes the reader waits one clock for registered data.
`timescale 1ns/1ps
`default_nettype none
module boot_msg_rom
    import boot_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst,
    input  wire logic   ce,
    boot_msg_if.mem     port
);
    logic [7:0] table_q [MSG_DEPTH];
    always_comb
    begin
        for (int i = 0; i < MSG_DEPTH; i++)
            table_q[i] = 8'h00;
        table_q[0]  = 8'h53; table_q[1]  = 8'h79; table_q[2]  = 8'h6E;
        table_q[3]  = 8'h63; table_q[4]  = 8'h68; table_q[5]  = 8'h72;
        table_q[6]  = 8'h6F; table_q[7]  = 8'h6E; table_q[8]  = 8'h69;
        table_q[9]  = 8'h7A; table_q[10] = 8'h65; table_q[11] = 8'h64;
        table_q[12] = CHR_CR; table_q[13] = CHR_LF;
        table_q[16] = 8'h4F; table_q[17] = 8'h4B;
        table_q[18] = CHR_CR; table_q[19] = CHR_LF;
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            port.data <= 8'h00;
        else if (ce)
            port.data <= table_q[port.addr];
    end
endmodule
`default_nettype wire

// ===== sim/boot_select_autobaud_sync_assertions.sv
// Port checks of the boot sequencer, bound onto its top module.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module boot_sync_checker
    import boot_pkg::*;
#(
    parameter int DECIDE_CYCLES = DECIDE_CYC,
    parameter int DIV_W         = 16
)(
    input wire logic             REF_CLK,
    input wire logic             RST,
    input wire logic             TX_READY,
    input wire logic             CMD_PROTECTED,
    input wire logic             RUN_USER,
    input wire logic             PROG_MODE,
    input wire logic             ROUTE_SERIAL,
    input wire logic [DIV_W-1:0] BAUD_DIV,
    input wire logic             TX_VALID,
    input wire logic [7:0]       TX_DATA,
    input wire logic             CMD_ACTIVE,
    input wire logic             CMD_REFUSE,
    input wire logic             UNLOCKED,
    input wire logic [31:0]      ALIAS_BASE
);
    int cyc;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    //////////////////////////////////////////
    // Cycles since reset release
    always_ff @(posedge REF_CLK or posedge RST)
        if (RST)
            cyc <= 0;
        else if (cyc < 1000000)
            cyc <= cyc + 1;
    //////////////////////////////////////////
    a_mode_onehot: assert property (!(RUN_USER && PROG_MODE))
        else $error("both modes set");
    a_decide_bound: assert property (
        cyc > DECIDE_CYCLES + 30 |-> RUN_USER || PROG_MODE)
        else $error("no boot decision in time");
    a_mode_stands: assert property (
        RUN_USER || PROG_MODE |=> $stable({RUN_USER, PROG_MODE}))
        else $error("mode changed");
    a_route_serial: assert property (PROG_MODE |-> ROUTE_SERIAL)
        else $error("serial not routed");
    a_alias_base: assert property (ALIAS_BASE == BOOT_BASE)
        else $error("alias base wrong");
    a_user_quiet: assert property (
        RUN_USER |-> !TX_VALID && !CMD_ACTIVE)
        else $error("serial active in user mode");
    a_tx_hold: assert property (
        TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
        else $error("tx byte dropped");
    a_baud_kept: assert property (CMD_ACTIVE |=> $stable(BAUD_DIV))
        else $error("divider moved");
    a_refuse_locked: assert property (
        CMD_ACTIVE && !UNLOCKED && CMD_PROTECTED |=> CMD_REFUSE)
        else $error("locked command not refused");
    a_refuse_cause: assert property (
        CMD_REFUSE |-> $past(CMD_PROTECTED) && !$past(UNLOCKED))
        else $error("refuse without cause");
    c_user: cover property ($rose(RUN_USER));
    c_refuse: cover property (CMD_REFUSE);
    c_line_end: cover property (TX_VALID && TX_READY && TX_DATA == CHR_LF);
endmodule
bind boot_select_autobaud_sync boot_sync_checker #(
    .DECIDE_CYCLES(DECIDE_CYCLES), .DIV_W(DIV_W)) chk_u (
    .REF_CLK, .RST, .TX_READY, .CMD_PROTECTED, .RUN_USER, .PROG_MODE,
    .ROUTE_SERIAL, .BAUD_DIV, .TX_VALID, .TX_DATA, .CMD_ACTIVE,
    .CMD_REFUSE, .UNLOCKED, .ALIAS_BASE);
`default_nettype wire

// ===== sim/boot_host.sv
// Host model: sync character on the line, byte strobes, reply drain.
// Assumes the bench seeds the random generator and calls its tasks.
`timescale 1ns/1ps
`default_nettype none
module boot_host
    import boot_pkg::*;
(
    input  wire logic       clk,
    output logic            line,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready
);
    initial
    begin
        line = 1'h1;
        rx_valid = 1'h0;
        rx_data = 8'hA5;
        tx_ready = 1'h0;
    end
    // Received byte strobe; data scrambled once released
    task automatic put(input logic [7:0] b);
        @(negedge clk);
        rx_data <= b;
        rx_valid <= 1'h1;
        @(negedge clk);
        rx_valid <= 1'h0;
        rx_data <= ~b;
        repeat (3) @(negedge clk);
    endtask
    task automatic sync_char(input int bc);
        logic [9:0] f;
        f = {1'h1, SYNC_CHAR, 1'h0};
        for (int i = 0; i < 10; i++)
        begin
            @(negedge clk);
            line <= f[i];
            repeat (bc - 1) @(negedge clk);
        end
        put(SYNC_CHAR);
    endtask
    // Stalls a random while before taking a reply byte
    task automatic getc(output logic [7:0] b, output bit ok);
        int n;
        repeat ($urandom_range(1, 5)) @(negedge clk);
        tx_ready <= 1'h1;
        for (n = 0; n < 300 && tx_valid !== 1'h1; n++)
            @(negedge clk);
        b = tx_data;
        ok = n < 300;
        @(negedge clk);
        tx_ready <= 1'h0;
    endtask
endmodule
`default_nettype wire

// ===== sim/boot_select_autobaud_sync_bench.sv
// Self-checking bench: boot decisions, then a full sync session.
// Assumes boot_host on the serial side and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module boot_select_autobaud_sync_bench
    import boot_pkg::*;
;
    localparam int           DC  = 10;
    localparam logic [111:0] SYN = {"Synchronized", CHR_CR, CHR_LF};
    logic        clk = 1'h0, rst = 1'h1, ce = 1'h1, unl = 1'h0, prot = 1'h0;
    logic        wdt = 1'h0, eight = 1'h0, p1 = 1'h1, p12 = 1'h1;
    logic        line, rxv, txr, ru, pm, rs, txv, ca, cr, ul;
    logic [7:0]  ver = 8'h00, rxd, txd;
    logic [2:0]  vi;
    logic [15:0] bd;
    logic [31:0] pw = 32'h0, ab, vw, vec [8] = '{default: 32'h0};
    int          fails = 0, samples_checked = 0;
    always #20 clk = ~clk;
    assign vw = vec[vi];
    boot_select_autobaud_sync #(.DECIDE_CYCLES(DC)) dut_u (
        .REF_CLK(clk), .RST(rst), .CE(ce), .WDT_OVERFLOW(wdt),
        .LOADER_VERSION(ver), .PKG_EIGHT_PIN(eight), .GPIO_LINE_ONE(p1),
        .GPIO_LINE_TWELVE(p12), .GPIO_LINE_ZERO(line), .PROT_WORD(pw),
        .VEC_WORD(vw), .RX_VALID(rxv), .RX_DATA(rxd), .TX_READY(txr),
        .CMD_UNLOCK(unl), .CMD_PROTECTED(prot), .VEC_INDEX(vi),
        .ALIAS_BASE(ab), .RUN_USER(ru), .PROG_MODE(pm), .ROUTE_SERIAL(rs),
        .BAUD_DIV(bd), .TX_VALID(txv), .TX_DATA(txd), .CMD_ACTIVE(ca),
        .CMD_REFUSE(cr), .UNLOCKED(ul));
    boot_host host_u (.clk(clk), .line(line), .rx_valid(rxv),
        .rx_data(rxd), .tx_valid(txv), .tx_data(txd), .tx_ready(txr));
    //////////////////////////////////////////
    task automatic cmp(input logic [31:0] got, exp, input int tol = 0);
        samples_checked++;
        if (^got === 1'hx || got > exp + tol || got + tol < exp)
        begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        if (fails == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic limit(input bit ok);
        if (!ok)
        begin
            fails++;
            close_out();
        end
    endtask
    // k = {watchdog, eight-pin, line one, line twelve, code valid}
    task automatic boot(input logic [4:0] k, input logic [7:0] v,
                        input logic [31:0] c);
        int          n;
        logic [31:0] s;
        logic        pin;
        @(negedge clk);
        rst = 1'h1;
        {wdt, eight, p1, p12, ver, pw} = {k[4:1], v, c};
        s = 32'h0;
        for (n = 0; n < 7; n++)
        begin
            vec[n] = $urandom;
            s += vec[n];
        end
        vec[7] = k[0] ? -s : 32'h1 - s;
        pin = (v >= VER_SPLIT && !k[3]) ? k[1] : k[2];
        repeat (12) @(negedge clk);
        rst = 1'h0;
        for (n = 0; n < DC + 40 && ru !== 1'h1 && pm !== 1'h1; n++)
            @(negedge clk);
        limit(n < DC + 40);
        pin = (!k[4] && c !== PROT_NO_SAMPLE && !pin) || !k[0];
        cmp({pm, ru}, pin ? 2'h2 : 2'h1);
        cmp(rs, pm);
        cmp(ab, BOOT_BASE);
    endtask
    task automatic take(input logic [111:0] s, input int n);
        logic [7:0] b;
        bit         ok;
        for (int i = n - 1; i >= 0; i--)
        begin
            host_u.getc(b, ok);
            limit(ok);
            cmp(b, s[8*i +: 8]);
        end
    endtask
    task automatic give(input logic [111:0] s, input int n, input int bad);
        for (int i = n - 1; i >= 0; i--)
            host_u.put(s[8*i +: 8] ^ {7'h0, i == bad});
    endtask
    //////////////////////////////////////////
    initial
    begin
        int         n;
        int         bc;
        logic [15:0] div;
        void'($urandom(32'hA9EB64AD));
        boot(5'h05, 8'h04, 32'h0);
        boot(5'h03, 8'h03, 32'h0);
        boot(5'h0B, 8'h04, 32'h0);
        boot(5'h11, 8'h04, 32'h0);
        boot(5'h01, 8'h04, PROT_NO_SAMPLE);
        boot(5'h06, 8'h04, 32'h0);
        boot(5'h07, 8'h04, 32'h0);
        repeat (20)
            boot(5'($urandom), 8'($urandom_range(0, 8)),
                 $urandom_range(0, 1) ? PROT_NO_SAMPLE : $urandom);
        boot(5'h05, 8'h04, 32'h0);
        host_u.put(8'h41);
        repeat (20) @(negedge clk);
        cmp(txv, 0);
        bc = $urandom_range(20, 60);
        for (n = 0; n < 2; n++)
        begin
            host_u.sync_char(bc);
            take(SYN, 14);
            cmp(bd, bc * 12 / 25, 2);
            give(SYN, 14, n ? -1 : 5);
            if (n == 0)
            begin
                repeat (40) @(negedge clk);
                cmp(txv, 0);
            end
        end
        take({"OK", CHR_CR, CHR_LF}, 4);
        div = bd;
        give({"12000", CHR_LF}, 6, -1);
        for (n = 0; n < 40 && ca !== 1'h1; n++)
            @(negedge clk);
        limit(n < 40);
        cmp(bd, div);
        // Unlock offered while frozen must not take
        ce = 1'h0;
        unl = 1'h1;
        @(negedge clk);
        {ce, unl} = 2'h2;
        cmp(ul, 0);
        prot = 1'h1;
        @(negedge clk);
        prot = 1'h0;
        cmp(cr, 1);
        unl = 1'h1;
        @(negedge clk);
        unl = 1'h0;
        prot = 1'h1;
        @(negedge clk);
        prot = 1'h0;
        cmp({ul, cr}, 2'h2);
        boot(5'h05, 8'h04, 32'h0);
        cmp(ul, 0);
        close_out();
    end
endmodule
`default_nettype wire
